/* common/pmw_pkg.sv */
// constants, register map and state codes of the power-mode and wake control
package pmw_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] PMW_OFF_MODE_SEL  = 8'h00;
    localparam logic [7:0] PMW_OFF_START_LOW = 8'h04;
    localparam logic [7:0] PMW_OFF_START_HI  = 8'h08;
    localparam logic [7:0] PMW_OFF_HW_WAKE   = 8'h0c;
    localparam logic [7:0] PMW_OFF_KEEP_CFG  = 8'h10;
    localparam logic [7:0] PMW_OFF_STATUS    = 8'h14;
    // values after reset
    localparam logic [1:0]  PMW_RST_MODE_SEL  = 2'h0;
    localparam logic [15:0] PMW_RST_START_LOW = 16'h0000;
    localparam logic [7:0]  PMW_RST_START_HI  = 8'h00;
    localparam logic [1:0]  PMW_RST_HW_WAKE   = 2'h0;
    localparam logic [11:0] PMW_RST_KEEP_CFG  = 12'h010;
    localparam logic [12:0] PMW_RST_DOMAIN    = 13'h1fff;
    // requested mode codes
    localparam logic [1:0] PMW_SEL_SLEEP = 2'h0;
    localparam logic [1:0] PMW_SEL_DEEP  = 2'h1;
    localparam logic [1:0] PMW_SEL_DPD   = 2'h2;
    localparam logic [1:0] PMW_SEL_FDPD  = 2'h3;
    // low wake source bits
    localparam int PMW_W_PIN      = 0;
    localparam int PMW_W_WDOG     = 1;
    localparam int PMW_W_RTC_1HZ  = 2;
    localparam int PMW_W_RTC_ALRM = 3;
    localparam int PMW_W_RTC_WAKE = 4;
    localparam int PMW_W_UTICK    = 5;
    localparam int PMW_W_OSTIMER  = 6;
    localparam int PMW_W_USART    = 7;
    localparam int PMW_W_SPI      = 8;
    localparam int PMW_W_I2C      = 9;
    localparam int PMW_W_I2S      = 10;
    localparam int PMW_W_I3C      = 11;
    localparam int PMW_W_USB      = 12;
    localparam int PMW_W_DMA0     = 13;
    localparam int PMW_W_DMA1     = 14;
    localparam int PMW_W_MIC      = 15;
    // high wake source bits: flash, sdio, hash, crypto, math, adc, dsp, hw
    localparam int PMW_W_HW_WAKE  = 7;
    // domain enable bits; keep-config uses bits 0 to 11
    localparam int PMW_D_LP_OSC   = 0;
    localparam int PMW_D_RTC      = 4;
    localparam int PMW_D_CMP      = 11;
    localparam int PMW_D_ROM      = 12;
    // mode states, one-hot
    typedef enum logic [4:0] {
        PMW_ST_ACTIVE = 5'h01,
        PMW_ST_SLEEP  = 5'h02,
        PMW_ST_DEEP   = 5'h04,
        PMW_ST_DPD    = 5'h08,
        PMW_ST_FDPD   = 5'h10
    } pmw_state_t;
endpackage

/* verilog/pmw_ctrl.sv */
// power-mode sequencing and wake-up gathering for the reduced power modes
// Functional notes
// - power-downs switch off oscillators, plls, sram, adc, comparator
// - rtc and its oscillator follow software in every mode
// - comparator may stay powered in deep-sleep but never wakes it
// - any enabled peripheral interrupt wakes the cpu from sleep
// - activity wake ends sleep, and selected activity ends deep-sleep
// - only the primary watchdog interrupt wakes from deep-sleep
// - only primary watchdog resets the chip; that reset ends deep-sleep
// - rtc 1 hz, rtc alarm and wake, tick and os timers wake deep-sleep
// - tick timer wakes deep-sleep while main clocks are stopped
// - usart wakes deep-sleep only in slave or 32 khz clock mode
// - spi, i2c, i2s, i3c wake deep-sleep only in slave mode
// - usb need-clock interrupt wakes deep-sleep
// - pins, dma, microphone, flash, sdio, accelerators, adc wake deep-sleep
// - dsp message interrupt may wake from deep-sleep
// - power-down ends on reset pin, rtc alarm or wake, or pmic interrupt pin
// - sleep stops the cpu clock until reset or interrupt
// - deep-sleep gates main, peripheral and cpu clocks
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module pmw_ctrl
    import pmw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        cpu_sleep_entry,
    input  wire logic [31:0] cpu_irq_pending,
    input  wire logic [15:0] wake_src_low,
    input  wire logic [7:0]  wake_src_high,
    input  wire logic        usart_slave,
    input  wire logic        usart_lowclk,
    input  wire logic        spi_slave,
    input  wire logic        i2c_slave,
    input  wire logic        i2s_slave,
    input  wire logic        i3c_slave,
    input  wire logic        serial_activity,
    input  wire logic        microphone_activity,
    input  wire logic        cmp_irq,
    input  wire logic        primary_watchdog_rst,
    input  wire logic        reset_pin_n,
    input  wire logic        power_manager_irq_pin_n,
    output logic      [4:0]  mode_state,
    output logic             cpu_clk_en,
    output logic             main_clk_en,
    output logic             periph_clk_en,
    output logic      [12:0] domain_en,
    output logic             wake_req,
    output logic             chip_rst
);
    pmw_state_t  state_reg;
    pmw_state_t  state_next;
    logic [1:0]  mode_sel_reg;
    logic [15:0] start_enable_low_reg;
    logic [7:0]  start_enable_high_reg;
    logic [1:0]  hw_wake_ctrl_reg;
    logic [11:0] keep_cfg_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [12:0] dom_reg;
    logic [12:0] dom_next;
    logic        cpu_clk_reg;
    logic        main_clk_reg;
    logic        periph_clk_reg;
    logic        wake_reg;
    logic        chip_rst_reg;

    // register decode
    wire sel_mode  = reg_addr == PMW_OFF_MODE_SEL;
    wire sel_low   = reg_addr == PMW_OFF_START_LOW;
    wire sel_high  = reg_addr == PMW_OFF_START_HI;
    wire sel_hw    = reg_addr == PMW_OFF_HW_WAKE;
    wire sel_keep  = reg_addr == PMW_OFF_KEEP_CFG;
    wire sel_stat  = reg_addr == PMW_OFF_STATUS;

    // qualify serial sources by their operating mode
    wire usart_ok = usart_slave | usart_lowclk;
    // bits 0-6 and 12-15 need no mode; usb, dma, mic pass straight
    wire [15:0] mode_mask = {4'hf, i3c_slave, i2s_slave, i2c_slave,
                             spi_slave, usart_ok, 7'h7f};
    wire [15:0] qual_low = wake_src_low & mode_mask;
    // hardware activity wake: bit0 for sleep, bit1 for deep-sleep
    wire hw_act = serial_activity | microphone_activity;
    wire hw_sleep = hw_act & hw_wake_ctrl_reg[0];
    wire [7:0] qual_high = {wake_src_high[7] | (hw_act & hw_wake_ctrl_reg[1]),
                            wake_src_high[6:0]};
    // deep-sleep wake: enabled sources only, comparator has no path
    wire deep_wake = |(qual_low & start_enable_low_reg) |
                     |(qual_high & start_enable_high_reg);
    wire sleep_wake = |cpu_irq_pending | hw_sleep;
    wire pd_wake = wake_src_low[PMW_W_RTC_ALRM] |
                   wake_src_low[PMW_W_RTC_WAKE] |
                   ~power_manager_irq_pin_n;
    wire pin_rst = ~reset_pin_n;

    // mode sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PMW_ST_ACTIVE: begin
                // a pending chip reset must not be followed by a mode entry
                if (cpu_sleep_entry && !pin_rst && !primary_watchdog_rst) begin
                    case (mode_sel_reg)
                        PMW_SEL_SLEEP: state_next = PMW_ST_SLEEP;
                        PMW_SEL_DEEP:  state_next = PMW_ST_DEEP;
                        PMW_SEL_DPD:   state_next = PMW_ST_DPD;
                        default:       state_next = PMW_ST_FDPD;
                    endcase
                end
            end
            PMW_ST_SLEEP: begin
                if (pin_rst || sleep_wake || primary_watchdog_rst) begin
                    state_next = PMW_ST_ACTIVE;
                end
            end
            PMW_ST_DEEP: begin
                if (pin_rst || deep_wake || primary_watchdog_rst) begin
                    state_next = PMW_ST_ACTIVE;
                end
            end
            PMW_ST_DPD, PMW_ST_FDPD: begin
                if (pin_rst || pd_wake) begin
                    state_next = PMW_ST_ACTIVE;
                end
            end
            default: state_next = PMW_ST_ACTIVE;
        endcase
    end

    // domain enables follow the next state so they align with mode_state
    always_comb begin
        dom_next = {1'b1, keep_cfg_reg};
        case (state_next)
            PMW_ST_ACTIVE: dom_next = {1'b1, 7'h7f, keep_cfg_reg[PMW_D_RTC],
                                       4'hf};
            PMW_ST_SLEEP:  dom_next = {1'b1, keep_cfg_reg};
            PMW_ST_DEEP:   dom_next = {1'b0, keep_cfg_reg};
            PMW_ST_DPD, PMW_ST_FDPD: begin
                dom_next = 13'h0000;
                dom_next[PMW_D_RTC] = keep_cfg_reg[PMW_D_RTC];
            end
            default:       dom_next = {1'b1, keep_cfg_reg};
        endcase
    end

    // read data, valid only in the cycle after the strobe
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (reg_rd) begin
            if (sel_mode)  rdata_next = {30'h0, mode_sel_reg};
            if (sel_low)   rdata_next = {16'h0, start_enable_low_reg};
            if (sel_high)  rdata_next = {24'h0, start_enable_high_reg};
            if (sel_hw)    rdata_next = {30'h0, hw_wake_ctrl_reg};
            if (sel_keep)  rdata_next = {20'h0, keep_cfg_reg};
            if (sel_stat)  rdata_next = {26'h0, wake_reg, state_reg};
        end
    end

    // software registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_sel_reg          <= PMW_RST_MODE_SEL;
            start_enable_low_reg  <= PMW_RST_START_LOW;
            start_enable_high_reg <= PMW_RST_START_HI;
            hw_wake_ctrl_reg      <= PMW_RST_HW_WAKE;
            keep_cfg_reg          <= PMW_RST_KEEP_CFG;
            rdata_reg             <= 32'h0000_0000;
        end else if (ce) begin
            if (reg_wr && sel_mode) mode_sel_reg <= reg_wdata[1:0];
            if (reg_wr && sel_low)  start_enable_low_reg <= reg_wdata[15:0];
            if (reg_wr && sel_high) start_enable_high_reg <= reg_wdata[7:0];
            if (reg_wr && sel_hw)   hw_wake_ctrl_reg <= reg_wdata[1:0];
            if (reg_wr && sel_keep) keep_cfg_reg <= reg_wdata[11:0];
            rdata_reg <= rdata_next;
        end
    end

    // state and registered outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg      <= PMW_ST_ACTIVE;
            dom_reg        <= PMW_RST_DOMAIN;
            cpu_clk_reg    <= 1'b1;
            main_clk_reg   <= 1'b1;
            periph_clk_reg <= 1'b1;
            wake_reg       <= 1'b0;
            chip_rst_reg   <= 1'b0;
        end else if (ce) begin
            state_reg      <= state_next;
            dom_reg        <= dom_next;
            cpu_clk_reg    <= state_next == PMW_ST_ACTIVE;
            main_clk_reg   <= state_next inside {PMW_ST_ACTIVE,
                                                 PMW_ST_SLEEP};
            periph_clk_reg <= state_next inside {PMW_ST_ACTIVE,
                                                 PMW_ST_SLEEP};
            wake_reg       <= state_reg != PMW_ST_ACTIVE &&
                              state_next == PMW_ST_ACTIVE;
            chip_rst_reg   <= primary_watchdog_rst;
        end
    end

    assign reg_rdata     = rdata_reg;
    assign mode_state    = state_reg;
    assign cpu_clk_en    = cpu_clk_reg;
    assign main_clk_en   = main_clk_reg;
    assign periph_clk_en = periph_clk_reg;
    assign domain_en     = dom_reg;
    assign wake_req      = wake_reg;
    assign chip_rst      = chip_rst_reg;

    // checks
    wire in_pd = state_reg inside {PMW_ST_DPD, PMW_ST_FDPD};
    property p_pd_off;
        @(posedge clk) disable iff (!rst_n)
        in_pd |-> (domain_en & 13'h1fef) == 13'h0000;
    endproperty
    a_pd_off: assert property (p_pd_off) else $error("domain on in pd");
    property p_rtc_sw;
        @(posedge clk) disable iff (!rst_n)
        ce && state_next != PMW_ST_ACTIVE |=>
            domain_en[PMW_D_RTC] == $past(keep_cfg_reg[PMW_D_RTC]);
    endproperty
    a_rtc_sw: assert property (p_rtc_sw) else $error("rtc not sw");
    property p_cmp_quiet;
        @(posedge clk) disable iff (!rst_n)
        ce && state_reg == PMW_ST_DEEP && cmp_irq && wake_src_low == 0 &&
        wake_src_high == 0 && !hw_act && reset_pin_n &&
        !primary_watchdog_rst |=> state_reg == PMW_ST_DEEP;
    endproperty
    a_cmp_quiet: assert property (p_cmp_quiet) else $error("cmp woke");
    property p_sleep_wake;
        @(posedge clk) disable iff (!rst_n)
        ce && state_reg == PMW_ST_SLEEP && |cpu_irq_pending
            |=> state_reg == PMW_ST_ACTIVE && wake_req && cpu_clk_en;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("no wake");
    property p_wdog_rst;
        @(posedge clk) disable iff (!rst_n)
        ce && primary_watchdog_rst |=> chip_rst &&
            state_reg != PMW_ST_DEEP && state_reg != PMW_ST_SLEEP;
    endproperty
    a_wdog_rst: assert property (p_wdog_rst) else $error("wdog rst");
    property p_usart_gate;
        @(posedge clk) disable iff (!rst_n)
        ce && state_reg == PMW_ST_DEEP && !usart_slave && !usart_lowclk &&
        wake_src_low == 16'h0080 && wake_src_high == 0 && !hw_act &&
        reset_pin_n && !primary_watchdog_rst |=> state_reg == PMW_ST_DEEP;
    endproperty
    a_usart_gate: assert property (p_usart_gate) else $error("usart");
    property p_pd_exit;
        @(posedge clk) disable iff (!rst_n)
        ce && in_pd && !power_manager_irq_pin_n
            |=> state_reg == PMW_ST_ACTIVE ##1 !wake_req;
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("pd no exit");
    property p_pin_rst;
        @(posedge clk) disable iff (!rst_n)
        ce && !reset_pin_n && state_reg != PMW_ST_ACTIVE
            |=> state_reg == PMW_ST_ACTIVE;
    endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("pin rst");
    property p_deep_clk;
        @(posedge clk) disable iff (!rst_n)
        state_reg == PMW_ST_DEEP |-> !main_clk_en && !periph_clk_en &&
            !cpu_clk_en && !domain_en[PMW_D_ROM];
    endproperty
    a_deep_clk: assert property (p_deep_clk) else $error("deep clk");
    c_sleep: cover property (@(posedge clk) disable iff (!rst_n)
        state_reg == PMW_ST_SLEEP ##1 state_reg == PMW_ST_ACTIVE);
    c_deep: cover property (@(posedge clk) disable iff (!rst_n)
        state_reg == PMW_ST_DEEP ##1 wake_req);
    c_fdpd: cover property (@(posedge clk) disable iff (!rst_n)
        state_reg == PMW_ST_FDPD ##1 state_reg == PMW_ST_ACTIVE);
endmodule
`default_nettype wire

/* sim/pmw_wake_model.sv */
// far-side model: wake sources that hold until served, and the sleeping cpu
`timescale 1ns/10ps
`default_nettype none
module pmw_wake_model
    import pmw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [4:0]  mode_state,
    input  wire logic        wake_req,
    input  wire logic [15:0] low_set,
    input  wire logic [7:0]  high_set,
    input  wire logic [31:0] irq_set,
    input  wire logic [31:0] irq_mask,
    input  wire logic        sleep_go,
    output logic      [15:0] wake_src_low,
    output logic      [7:0]  wake_src_high,
    output logic      [31:0] cpu_irq_pending,
    output logic             cpu_sleep_entry
);
    logic [31:0] irq_held;
    logic        awake;
    // a request stays up until the woken cpu has served it
    always_ff @(posedge clk) begin
        if (!rst_n || wake_req) begin
            wake_src_low  <= 16'h0;
            wake_src_high <= 8'h0;
            irq_held      <= 32'h0;
        end else begin
            wake_src_low  <= wake_src_low | low_set;
            wake_src_high <= wake_src_high | high_set;
            irq_held      <= irq_held | irq_set;
        end
    end
    // only lines enabled in the cpu_interrupt_controller show as pending
    assign cpu_irq_pending = irq_held & irq_mask;
    // a stopped cpu cannot execute the sleep instruction again
    assign awake = (mode_state == PMW_ST_ACTIVE);
    always_ff @(posedge clk) begin
        cpu_sleep_entry <= rst_n && sleep_go && awake;
    end
endmodule
`default_nettype wire

/* sim/tb_pmw_ctrl.sv */
// bench for the power-mode and wake control with a far-side wake model
`timescale 1ns/10ps
`default_nettype none
module tb_pmw_ctrl;
    import pmw_pkg::*;
    logic        clk, rst_n, ce, reg_wr, reg_rd, sleep_go, cmp_irq;
    logic        cpu_clk_en, main_clk_en, periph_clk_en, wake_req, chip_rst;
    logic        cpu_sleep_entry;
    logic [7:0]  reg_addr, wake_src_high, high_set;
    logic [31:0] reg_wdata, reg_rdata, irq_mask, irq_set, cpu_irq_pending;
    logic [15:0] wake_src_low, low_set;
    logic [23:0] m;
    logic [5:0]  qual;
    logic [4:0]  pins, mode_state;
    logic [12:0] domain_en;
    int          err_total, samples_checked, wakes, w0, rsts;
    logic [7:0]  offs [7] = '{PMW_OFF_MODE_SEL, PMW_OFF_START_LOW,
        PMW_OFF_START_HI, PMW_OFF_HW_WAKE, PMW_OFF_KEEP_CFG, PMW_OFF_STATUS,
        8'h18};
    logic [31:0] rvals [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h10, 32'h1,
        32'h0};
    pmw_ctrl dut (.clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cpu_sleep_entry, .cpu_irq_pending, .wake_src_low,
        .wake_src_high, .usart_slave(qual[0]), .usart_lowclk(qual[1]),
        .spi_slave(qual[2]), .i2c_slave(qual[3]), .i2s_slave(qual[4]),
        .i3c_slave(qual[5]), .primary_watchdog_rst(pins[0]),
        .serial_activity(pins[1]), .microphone_activity(pins[2]), .cmp_irq,
        .reset_pin_n(~pins[3]), .power_manager_irq_pin_n(~pins[4]),
        .mode_state, .cpu_clk_en, .main_clk_en, .periph_clk_en, .domain_en,
        .wake_req, .chip_rst);
    pmw_wake_model wm (.clk, .rst_n, .mode_state, .wake_req, .low_set,
        .high_set, .irq_set, .irq_mask, .sleep_go, .wake_src_low,
        .wake_src_high, .cpu_irq_pending, .cpu_sleep_entry);
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            err_total++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        check(reg_rdata, want);
    endtask
    // raise sources and pins for one cycle; the model holds the sources, not the pins, until served
    task automatic fire(input logic [15:0] l, input logic [7:0] h,
                        input logic [31:0] q, input logic [4:0] p);
        @(posedge clk);
        low_set  <= l;
        high_set <= h;
        irq_set  <= q;
        pins     <= p;
        @(posedge clk);
        low_set  <= 16'h0;
        high_set <= 8'h0;
        irq_set  <= 32'h0;
        pins     <= 5'h0;
    endtask
    task automatic expect_mode(input logic [4:0] st, input int dw);
        repeat (3) @(posedge clk);
        #1;
        check({27'h0, mode_state}, {27'h0, st});
        check(32'(wakes - w0), 32'(dw));
        w0 = wakes;
    endtask
    task automatic enter(input logic [1:0] sel);
        wr(PMW_OFF_MODE_SEL, {30'h0, sel});
        @(posedge clk);
        sleep_go <= 1'b1;
        @(posedge clk);
        sleep_go <= 1'b0;
        expect_mode(5'h02 << sel, 0);
    endtask
    task automatic outs(input logic [2:0] ck, input logic [12:0] dm);
        check({29'h0, cpu_clk_en, main_clk_en, periph_clk_en}, {29'h0, ck});
        check({19'h0, domain_en}, {19'h0, dm});
    endtask
    task automatic test_done();
        if (err_total == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // count wake pulses and chip resets driven by the design
    always @(posedge clk) begin
        wakes <= wakes + int'(wake_req === 1'b1);
        rsts  <= rsts + int'(chip_rst === 1'b1);
    end
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // cut a hang short well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        test_done();
    end
    initial begin
        {rst_n, reg_wr, reg_rd, sleep_go, cmp_irq, pins, qual} = 16'h0;
        {reg_addr, low_set, high_set, irq_set, reg_wdata} = 96'h0;
        ce       = 1'b1;
        irq_mask = 32'hffffffff;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // register values after reset, unmapped read, frozen write
        for (int i = 0; i < 7; i++) begin
            rd(offs[i], rvals[i]);
        end
        outs(3'h7, 13'h1fff);
        ce <= 1'b0;
        wr(PMW_OFF_KEEP_CFG, 32'h0);
        ce <= 1'b1;
        rd(PMW_OFF_KEEP_CFG, 32'h10);
        // deep-sleep: clocks off, kept domains on, comparator never wakes
        wr(PMW_OFF_KEEP_CFG, 32'h810);
        enter(PMW_SEL_DEEP);
        outs(3'h0, 13'h0810);
        cmp_irq <= 1'b1;
        fire(16'h0020, 8'h0, 32'h0, 5'h0);
        expect_mode(PMW_ST_DEEP, 0);
        wr(PMW_OFF_START_LOW, 32'h20);
        expect_mode(PMW_ST_ACTIVE, 1);
        cmp_irq <= 1'b0;
        // every deep-sleep source wakes only through its own enable bit
        qual <= 6'h3f;
        for (int i = 0; i < 24; i++) begin
            m = 24'h1 << i;
            wr(PMW_OFF_START_LOW, {16'h0, m[15:0]});
            wr(PMW_OFF_START_HI, {24'h0, m[23:16]});
            enter(PMW_SEL_DEEP);
            fire(~m[15:0], ~m[23:16], 32'h0, 5'h0);
            expect_mode(PMW_ST_DEEP, 0);
            fire(m[15:0], m[23:16], 32'h0, 5'h0);
            expect_mode(PMW_ST_ACTIVE, 1);
        end
        // serial wakes need slave mode, the usart slave mode or the slow clock
        qual <= 6'h0;
        wr(PMW_OFF_START_LOW, 32'hf80);
        enter(PMW_SEL_DEEP);
        fire(16'h0080, 8'h0, 32'h0, 5'h0);
        expect_mode(PMW_ST_DEEP, 0);
        fire(16'h0f00, 8'h0, 32'h0, 5'h0);
        expect_mode(PMW_ST_DEEP, 0);
        qual <= 6'h02;
        expect_mode(PMW_ST_ACTIVE, 1);
        qual <= 6'h0;
        enter(PMW_SEL_DEEP);
        fire(16'h0f00, 8'h0, 32'h0, 5'h0);
        expect_mode(PMW_ST_DEEP, 0);
        qual <= 6'h04;
        expect_mode(PMW_ST_ACTIVE, 1);
        // watchdog reset and hardware activity end deep-sleep
        wr(PMW_OFF_START_LOW, 32'h0);
        enter(PMW_SEL_DEEP);
        fire(16'h0, 8'h0, 32'h0, 5'h01);
        expect_mode(PMW_ST_ACTIVE, 1);
        wr(PMW_OFF_HW_WAKE, 32'h2);
        wr(PMW_OFF_START_HI, 32'h80);
        enter(PMW_SEL_DEEP);
        fire(16'h0, 8'h0, 32'h0, 5'h02);
        expect_mode(PMW_ST_ACTIVE, 1);
        // sleep: cpu clock stops, boot rom stays, irq or activity wakes
        wr(PMW_OFF_HW_WAKE, 32'h1);
        enter(PMW_SEL_SLEEP);
        outs(3'h3, 13'h1810);
        fire(16'h0, 8'h0, 32'h0, 5'h04);
        expect_mode(PMW_ST_ACTIVE, 1);
        wr(PMW_OFF_HW_WAKE, 32'h0);
        enter(PMW_SEL_SLEEP);
        fire(16'h0, 8'h0, 32'h0, 5'h06);
        expect_mode(PMW_ST_SLEEP, 0);
        fire(16'h0, 8'h0, 32'h8, 5'h0);
        expect_mode(PMW_ST_ACTIVE, 1);
        // power-down keeps only the rtc and ignores deep-sleep sources
        wr(PMW_OFF_START_LOW, 32'hffff);
        wr(PMW_OFF_START_HI, 32'hff);
        enter(PMW_SEL_DPD);
        outs(3'h0, 13'h0010);
        fire(16'hffe7, 8'hff, 32'hffffffff, 5'h06);
        expect_mode(PMW_ST_DPD, 0);
        fire(16'h0008, 8'h0, 32'h0, 5'h0);
        expect_mode(PMW_ST_ACTIVE, 1);
        wr(PMW_OFF_KEEP_CFG, 32'h800);
        enter(PMW_SEL_FDPD);
        outs(3'h0, 13'h0);
        fire(16'h0010, 8'h0, 32'h0, 5'h0);
        expect_mode(PMW_ST_ACTIVE, 1);
        // reset pin ends every mode, pmic pin ends both power-downs
        wr(PMW_OFF_START_LOW, 32'h0);
        wr(PMW_OFF_START_HI, 32'h0);
        for (int k = 0; k < 6; k++) begin
            enter(2'((k < 4) ? k : k - 2));
            fire(16'h0, 8'h0, 32'h0, (k < 4) ? 5'h08 : 5'h10);
            expect_mode(PMW_ST_ACTIVE, 1);
        end
        check(32'(rsts), 32'h1);
        test_done();
    end
endmodule
`default_nettype wire
